// ---- hdl/irq_tick_timer.sv ----
/*
 interrupt inactive gap after end of interrupt, and the cyclic user tick.
 assumes eoi is a one-cycle pulse from the core on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mode_cfg_consts.svh"
module irq_tick_timer #(
    parameter int unsigned GAP_LONG   = `GAP_LONG_CYC,
    parameter int unsigned TICK_SHORT = `TICK_SHORT_CYC,
    parameter int unsigned TICK_LONG  = `TICK_LONG_CYC
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // core side
    tm_if.timer       tm
);
    localparam logic [`CNT_W-1:0] GS = `CNT_W'(`GAP_SHORT_CYC - 1);
    localparam logic [`CNT_W-1:0] GL = `CNT_W'(GAP_LONG - 1);
    localparam logic [`CNT_W-1:0] TS = `CNT_W'(TICK_SHORT - 1);
    localparam logic [`CNT_W-1:0] TL = `CNT_W'(TICK_LONG - 1);
    mode_cfg_pkg::timer_t st;
    mode_cfg_pkg::timer_t n;
    logic [`CNT_W-1:0] gap_lim;
    logic [`CNT_W-1:0] tick_lim;

    assign gap_lim  = tm.gap_long ? GL : GS;
    assign tick_lim = tm.tick_long ? TL : TS;

    always_comb begin
        n = st;
        n.tick = 1'b0;
        // inactive time counted from the end of interrupt
        if (tm.eoi) begin
            n.gap_busy = 1'b1;
            n.gap_cnt = '0;
        end else if (st.gap_busy) begin
            n.gap_cnt = st.gap_cnt + 1'b1;
            if (st.gap_cnt == gap_lim) begin
                n.gap_busy = 1'b0;
            end
        end
        // tick runs only once the controller has left offline
        if (!tm.running) begin
            n.tick_cnt = '0;
        end else if (st.tick_cnt == tick_lim) begin
            n.tick_cnt = '0;
            n.tick = 1'b1;
        end else begin
            n.tick_cnt = st.tick_cnt + 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= n;
        end
    end

    assign tm.gap_busy = st.gap_busy;
    assign tm.tick = st.tick;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_gap_short_hold: assert property (
        tm.eoi && !tm.gap_long |=> st.gap_busy [*8])
        else $error("short interrupt gap ended early");
    a_gap_end_count: assert property (
        $fell(st.gap_busy) |-> $past(st.gap_cnt) == $past(gap_lim))
        else $error("interrupt gap length wrong");
    a_tick_period: assert property (
        st.tick |-> $past(st.tick_cnt) == $past(tick_lim)
                    && $past(tm.running))
        else $error("user tick period wrong");
endmodule
`default_nettype wire

// ---- hdl/mode_cfg.sv ----
/*
 static mode configuration of a fieldbus slave controller, with the
 offline/passive-idle run state, start command and interrupt pin shaping.
 assumes an AXI4-Lite master on aclk; controller-side inputs come from
 logic on the same clock.
*/
// Implementation choice: the AXI4-Lite slave port.
// How it works
// - bit 0 high turns start-bit check off; parameter telegram overwrites it
// - bit 1 high turns stop-bit check off; parameter telegram overwrites it
// - bit 3 picks minimum station delay: 0 pure slave, 1 combined
// - bit 4 sets interrupt pin polarity: 0 active low, 1 active high
// - bit 5 high gives the read answer one clock earlier
// - bit 6 declares synchronised output mode support
// - bit 7 declares frozen input mode support
// - bit 8 enables the slave protocol and its service points
// - bit 9 sets interrupt inactive gap: 1 us or 1 ms
// - bit 10 sets user tick period: 1 ms or 10 ms
// - bit 12 stores parameter data in the special parameter buffer
// - bit 13 accepts zero-length data telegrams in data exchange
// - start command leaves offline, starts timers, clears go-offline request
`timescale 1ns/1ns
`default_nettype none
`include "mode_cfg_consts.svh"
module mode_cfg #(
    parameter int unsigned GAP_LONG   = `GAP_LONG_CYC,
    parameter int unsigned TICK_SHORT = `TICK_SHORT_CYC,
    parameter int unsigned TICK_LONG  = `TICK_LONG_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // controller events
    input  wire logic        link_busy,
    input  wire logic        prm_load,
    input  wire logic        prm_start_off,
    input  wire logic        prm_stop_off,
    input  wire logic        irq_event,
    // mode outputs
    output logic             start_bit_check_off,
    output logic             stop_bit_check_off,
    output logic             distribution_receive_enable,
    output logic             min_station_delay_select,
    output logic             early_ready,
    output logic             sync_supported,
    output logic             freeze_supported,
    output logic             slave_protocol_enable,
    output logic             irq_gap_timebase,
    output logic             tick_timebase,
    output logic             watchdog_test_select,
    output logic             spec_prm_buffer_mode,
    output logic             fail_safe_clear_mode,
    // run state and interrupt
    output logic             passive_idle,
    output logic             timer_start,
    output logic             irq_out,
    output logic             user_tick
);
    mode_cfg_pkg::core_t st;
    mode_cfg_pkg::core_t n;
    mode_cfg_pkg::sel_t  wsel;
    mode_cfg_pkg::sel_t  rsel_now;
    logic [7:0]          rval;
    logic                wr_go;
    logic                cmd_hit;
    logic                cmd_leave;
    logic                cmd_eoi;
    logic                cmd_goff;
    logic                ar_take;
    tm_if                tm ();

    function automatic mode_cfg_pkg::sel_t reg_sel(input logic [7:0] a);
        case (a)
            {`IDX_STATUS, 2'h0}:  reg_sel = mode_cfg_pkg::SEL_STATUS;
            {`IDX_MODE_LO, 2'h0}: reg_sel = mode_cfg_pkg::SEL_MODE_LO;
            {`IDX_MODE_HI, 2'h0}: reg_sel = mode_cfg_pkg::SEL_MODE_HI;
            {`IDX_CMD, 2'h0}:     reg_sel = mode_cfg_pkg::SEL_CMD;
            default:              reg_sel = mode_cfg_pkg::SEL_NONE;
        endcase
    endfunction

    irq_tick_timer #(
        .GAP_LONG   (GAP_LONG),
        .TICK_SHORT (TICK_SHORT),
        .TICK_LONG  (TICK_LONG)
    ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tm      (tm.timer)
    );

    assign tm.gap_long  = st.mode[`B_GAP_TB];
    assign tm.tick_long = st.mode[`B_TICK_TB];
    assign tm.running   = (st.run == mode_cfg_pkg::PASSIVE);
    assign tm.eoi       = st.eoi;

    // write side decode
    assign wr_go     = st.aw_ok && st.w_ok && !st.bvalid;
    assign wsel      = reg_sel(st.aw_addr);
    assign cmd_hit   = wr_go && st.w_lane && (wsel == mode_cfg_pkg::SEL_CMD);
    assign cmd_leave = cmd_hit && st.w_data[`CMD_LEAVE];
    assign cmd_eoi   = cmd_hit && st.w_data[`CMD_EOI];
    assign cmd_goff  = cmd_hit && st.w_data[`CMD_GO_OFF];
    assign ar_take   = arvalid && st.arready;

    // read mux: address at take time, else the latched selection
    assign rsel_now = (st.rd == mode_cfg_pkg::RD_IDLE) ? reg_sel(araddr) : st.rsel;

    always_comb begin
        case (rsel_now)
            mode_cfg_pkg::SEL_STATUS:
                rval = {5'h00, tm.gap_busy, st.irq_pend, tm.running};
            mode_cfg_pkg::SEL_MODE_LO:
                rval = st.mode[7:0];
            mode_cfg_pkg::SEL_MODE_HI:
                rval = {2'h0, st.mode[`MODE_W-1:8]};
            default:
                rval = 8'h00;
        endcase
    end

    always_comb begin
        n = st;
        n.timer_start = 1'b0;
        n.eoi = 1'b0;

        // address and data are taken independently, in either order
        if (awvalid && st.awready) begin
            n.aw_ok = 1'b1;
            n.aw_addr = awaddr;
        end
        if (wvalid && st.wready) begin
            n.w_ok = 1'b1;
            n.w_data = wdata[7:0];
            n.w_lane = wstrb[0];
        end
        if (st.bvalid && bready) begin
            n.bvalid = 1'b0;
        end

        if (wr_go) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = `RESP_OKAY;
            case (wsel)
                mode_cfg_pkg::SEL_MODE_LO: begin
                    // refused while running so a live link never sees a host write move it
                    if (st.run != mode_cfg_pkg::OFFLINE) begin
                        n.bresp = `RESP_SLVERR;
                    end else if (st.w_lane) begin
                        n.mode[7:0] = st.w_data;
                    end
                end
                mode_cfg_pkg::SEL_MODE_HI: begin
                    if (st.run != mode_cfg_pkg::OFFLINE) begin
                        n.bresp = `RESP_SLVERR;
                    end else if (st.w_lane) begin
                        n.mode[`MODE_W-1:8] = st.w_data[5:0];
                    end
                end
                mode_cfg_pkg::SEL_STATUS,
                mode_cfg_pkg::SEL_CMD: begin
                    n.bresp = `RESP_OKAY;
                end
                default: begin
                    n.bresp = `RESP_SLVERR;
                end
            endcase
        end

        // telegram overwrite comes last so it wins over a host write
        if (prm_load && st.mode[`B_PROTO]) begin
            n.mode[`B_START_OFF] = prm_start_off;
            n.mode[`B_STOP_OFF] = prm_stop_off;
        end

        // go offline once the current request has ended
        if (st.go_off_pend && !link_busy) begin
            n.run = mode_cfg_pkg::OFFLINE;
            n.go_off_pend = 1'b0;
        end
        if (cmd_goff && st.run == mode_cfg_pkg::PASSIVE) begin
            n.go_off_pend = 1'b1;
        end
        if (cmd_leave && st.run == mode_cfg_pkg::OFFLINE) begin
            n.run = mode_cfg_pkg::PASSIVE;
            n.timer_start = 1'b1;
            n.go_off_pend = 1'b0;
        end

        // end of interrupt clears, a new event in the same cycle wins
        if (cmd_eoi) begin
            n.irq_pend = 1'b0;
            n.eoi = 1'b1;
        end
        if (irq_event) begin
            n.irq_pend = 1'b1;
        end
        if (st.irq_pend && !tm.gap_busy) begin
            n.irq_pin = st.mode[`B_IRQ_POL];
        end else begin
            n.irq_pin = !st.mode[`B_IRQ_POL];
        end

        // read channel; early mode answers one cycle sooner
        case (st.rd)
            mode_cfg_pkg::RD_IDLE: begin
                if (ar_take) begin
                    n.rsel = rsel_now;
                    if (st.mode[`B_EARLY]) begin
                        n.rd = mode_cfg_pkg::RD_RESP;
                        n.rvalid = 1'b1;
                        n.rdata = rval;
                        n.rresp = (rsel_now == mode_cfg_pkg::SEL_NONE) ?
                                  `RESP_SLVERR : `RESP_OKAY;
                    end else begin
                        n.rd = mode_cfg_pkg::RD_WAIT;
                    end
                end
            end
            mode_cfg_pkg::RD_WAIT: begin
                n.rd = mode_cfg_pkg::RD_RESP;
                n.rvalid = 1'b1;
                n.rdata = rval;
                n.rresp = (rsel_now == mode_cfg_pkg::SEL_NONE) ?
                          `RESP_SLVERR : `RESP_OKAY;
            end
            mode_cfg_pkg::RD_RESP: begin
                if (rready) begin
                    n.rd = mode_cfg_pkg::RD_IDLE;
                    n.rvalid = 1'b0;
                end
            end
            default: begin
                n.rd = mode_cfg_pkg::RD_IDLE;
                n.rvalid = 1'b0;
            end
        endcase

        // one write and one read in flight at a time
        n.awready = !n.aw_ok && !n.bvalid && !wr_go;
        n.wready = !n.w_ok && !n.bvalid && !wr_go;
        n.arready = (n.rd == mode_cfg_pkg::RD_IDLE) && !ar_take;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.mode <= `MODE_RST;
            // inactive level for the reset polarity (active low)
            st.irq_pin <= 1'b1;
        end else begin
            st <= n;
        end
    end

    assign awready = st.awready;
    assign wready  = st.wready;
    assign bvalid  = st.bvalid;
    assign bresp   = st.bresp;
    assign arready = st.arready;
    assign rvalid  = st.rvalid;
    assign rresp   = st.rresp;
    assign rdata   = {24'h000000, st.rdata};

    assign start_bit_check_off         = st.mode[`B_START_OFF];
    assign stop_bit_check_off          = st.mode[`B_STOP_OFF];
    assign distribution_receive_enable = st.mode[`B_DIST_RX];
    assign min_station_delay_select    = st.mode[`B_MIN_TSD];
    assign early_ready                 = st.mode[`B_EARLY];
    assign sync_supported              = st.mode[`B_SYNC];
    assign freeze_supported            = st.mode[`B_FREEZE];
    assign slave_protocol_enable       = st.mode[`B_PROTO];
    assign irq_gap_timebase            = st.mode[`B_GAP_TB];
    assign tick_timebase               = st.mode[`B_TICK_TB];
    assign watchdog_test_select        = st.mode[`B_WATCHDOG_TEST_SELECT];
    assign spec_prm_buffer_mode        = st.mode[`B_SPEC_PRM];
    assign fail_safe_clear_mode        = st.mode[`B_FAIL_SAFE];
    assign passive_idle                = tm.running;
    assign timer_start                 = st.timer_start;
    assign irq_out                     = st.irq_pin;
    assign user_tick                   = tm.tick;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_prm_overwrite: assert property (
        prm_load && slave_protocol_enable |=>
            start_bit_check_off == $past(prm_start_off)
            && stop_bit_check_off == $past(prm_stop_off))
        else $error("telegram did not overwrite check bits");
    a_early_read: assert property (
        ar_take && early_ready |=> rvalid)
        else $error("early read answer late");
    a_normal_read: assert property (
        ar_take && !early_ready |=> !rvalid ##1 rvalid)
        else $error("normal read answer timing wrong");
    a_irq_pin_level: assert property (
        st.irq_pend && !tm.gap_busy |=> irq_out == $past(st.mode[`B_IRQ_POL]))
        else $error("interrupt pin level wrong");
    a_irq_gap_quiet: assert property (
        tm.gap_busy |=> irq_out == !$past(st.mode[`B_IRQ_POL]))
        else $error("interrupt active during gap");
    a_leave_offline: assert property (
        cmd_leave && !passive_idle |=>
            passive_idle && timer_start && !st.go_off_pend ##1 !timer_start)
        else $error("start command not honoured");
    a_mode_frozen: assert property (
        passive_idle && $past(passive_idle) |-> $stable(st.mode[`MODE_W-1:2]))
        else $error("mode changed while running");
    a_high_read_zero: assert property (
        rvalid && st.rsel == mode_cfg_pkg::SEL_MODE_HI |-> rdata[7:6] == 2'h0)
        else $error("upper mode bits not zero");
endmodule
`default_nettype wire

// ---- inc/mode_cfg_consts.svh ----
/*
 mode configuration constants: word indices, bit positions, reset values
 and timing counts. assumes a 10 MHz clock and a 32-bit register bus.
*/
`ifndef MODE_CFG_CONSTS_SVH
`define MODE_CFG_CONSTS_SVH
// word indices; byte address is index times four
`define IDX_STATUS   6'h04
`define IDX_MODE_LO  6'h06
`define IDX_MODE_HI  6'h07
`define IDX_CMD      6'h08
// mode bit positions
`define B_START_OFF  0
`define B_STOP_OFF   1
`define B_DIST_RX    2
`define B_MIN_TSD    3
`define B_IRQ_POL    4
`define B_EARLY      5
`define B_SYNC       6
`define B_FREEZE     7
`define B_PROTO      8
`define B_GAP_TB     9
`define B_TICK_TB    10
`define B_WATCHDOG_TEST_SELECT    11
`define B_SPEC_PRM   12
`define B_FAIL_SAFE  13
`define MODE_W       14
`define MODE_RST     14'h0000
// command bits and response codes
`define CMD_LEAVE    0
`define CMD_EOI      1
`define CMD_GO_OFF   2
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
// timing
`define CLK_NS       100
`define GAP_SHORT_NS 1000
`define GAP_LONG_NS  1000000
`define TICK_SHORT_NS 1000000
`define TICK_LONG_NS 10000000
`define GAP_SHORT_CYC ((`GAP_SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define GAP_LONG_CYC  ((`GAP_LONG_NS + `CLK_NS - 1) / `CLK_NS)
`define TICK_SHORT_CYC (`TICK_SHORT_NS / `CLK_NS)
`define TICK_LONG_CYC  (`TICK_LONG_NS / `CLK_NS)
`define CNT_W        17
`endif

// ---- inc/mode_cfg_pkg.sv ----
/*
 types of the mode configuration block.
 assumes mode_cfg_consts.svh is compiled alongside.
*/
`include "mode_cfg_consts.svh"
package mode_cfg_pkg;
    typedef enum logic {OFFLINE, PASSIVE} run_t;
    typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_RESP} rd_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_STATUS, SEL_MODE_LO,
                              SEL_MODE_HI, SEL_CMD} sel_t;
    typedef struct packed {
        run_t              run;
        logic [`MODE_W-1:0] mode;
        logic              go_off_pend;
        logic              aw_ok;
        logic [7:0]        aw_addr;
        logic              w_ok;
        logic [7:0]        w_data;
        logic              w_lane;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        rd_t               rd;
        sel_t              rsel;
        logic              rvalid;
        logic [7:0]        rdata;
        logic [1:0]        rresp;
        logic              irq_pend;
        logic              irq_pin;
        logic              timer_start;
        logic              eoi;
    } core_t;
    typedef struct packed {
        logic [`CNT_W-1:0] gap_cnt;
        logic              gap_busy;
        logic [`CNT_W-1:0] tick_cnt;
        logic              tick;
    } timer_t;
endpackage

// ---- inc/tm_if.sv ----
/*
 link between the register core and the interrupt/tick timer.
 assumes both ends sit on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface tm_if;
    logic gap_long;
    logic tick_long;
    logic running;
    logic eoi;
    logic gap_busy;
    logic tick;
    modport core (output gap_long, tick_long, running, eoi,
                  input gap_busy, tick);
    modport timer (input gap_long, tick_long, running, eoi,
                   output gap_busy, tick);
endinterface
`default_nettype wire

// ---- verif/fieldbus_slave_mode_config_tb.sv ----
/*
 bench: register access, start, telegram overwrite, interrupt, tick.
 assumes host_model and the design files are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mode_cfg_consts.svh"
module fieldbus_slave_mode_config_tb;
    localparam logic [7:0] A_ST = {`IDX_STATUS, 2'b00};
    localparam logic [7:0] A_LO = {`IDX_MODE_LO, 2'b00};
    localparam logic [7:0] A_HI = {`IDX_MODE_HI, 2'b00};
    localparam logic [7:0] A_CMD = {`IDX_CMD, 2'b00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr, araddr, d;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, hung, passive_idle, timer_start, irq_out, user_tick;
    logic link_busy = 1'b0;
    logic prm_load = 1'b0;
    logic prm_start_off = 1'b0;
    logic prm_stop_off = 1'b0;
    logic irq_event = 1'b0;
    wire [13:0] mo;
    int error_cnt = 0;
    int checks = 0;
    int starts = 0;
    int lat;
    assign mo[4] = 1'b0;
    mode_cfg #(.GAP_LONG(20), .TICK_SHORT(30), .TICK_LONG(50)) i_mode_cfg (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .link_busy, .prm_load, .prm_start_off, .prm_stop_off, .irq_event,
        .start_bit_check_off(mo[0]), .stop_bit_check_off(mo[1]),
        .distribution_receive_enable(mo[2]), .min_station_delay_select(mo[3]),
        .early_ready(mo[5]), .sync_supported(mo[6]), .freeze_supported(mo[7]),
        .slave_protocol_enable(mo[8]), .irq_gap_timebase(mo[9]), .tick_timebase(mo[10]),
        .watchdog_test_select(mo[11]), .spec_prm_buffer_mode(mo[12]),
        .fail_safe_clear_mode(mo[13]), .passive_idle, .timer_start, .irq_out, .user_tick);
    host_model i_host_model (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .hung);
    always #50 aclk = ~aclk;
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        if (timer_start === 1'b1) starts++;
        if (hung === 1'b1) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic t_reset();
        chk("irq_out", irq_out, 1);
        i_host_model.rd(A_HI, d, r, lat);
        chk("mode_hi", d, 0);
        i_host_model.rd(8'h3c, d, r, lat);
        chk("unmapped", r, `RESP_SLVERR);
        $display("t_reset done");
    endtask
    task automatic t_mode();
        i_host_model.wr(A_LO, 8'hdb, r); // bit2 kept zero
        i_host_model.wr(A_HI, 8'hf7, r); // bit11 kept zero
        // spec buffer on: aux sizing and its length cell are host ram work
        chk("mode_out", mo, 14'h37cb);
        chk("irq_idle", irq_out, 0);
        i_host_model.rd(A_HI, d, r, lat);
        chk("mode_hi", d, 8'h37);
        chk("lat_normal", lat, 2);
        i_host_model.wr(A_LO, 8'hfb, r);
        i_host_model.rd(A_LO, d, r, lat);
        chk("lat_early", lat, 1);
        $display("t_mode done");
    endtask
    task automatic t_prm();
        @(posedge aclk);
        prm_stop_off <= 1'b1;
        prm_load <= 1'b1;
        @(posedge aclk);
        prm_load <= 1'b0;
        @(negedge aclk);
        chk("prm_bits", mo[1:0], 2'b10);
        $display("t_prm done");
    endtask
    task automatic t_start();
        i_host_model.wr(A_CMD, 8'h01, r); // all loaded first
        // let the pulse counter see the same edge first
        @(negedge aclk);
        chk("running", passive_idle, 1);
        chk("timer_start", starts, 1);
        i_host_model.rd(A_ST, d, r, lat);
        chk("status", d[0], 1);
        i_host_model.wr(A_LO, 8'h00, r);
        chk("locked", r, `RESP_SLVERR);
        i_host_model.rd(A_LO, d, r, lat);
        chk("kept", d, 8'hfa);
        $display("t_start done");
    endtask
    task automatic t_tick_irq();
        int n;
        int t0;
        n = 0;
        do begin @(posedge aclk); n++; end while (user_tick !== 1'b1 && n < 200);
        t0 = n;
        do begin @(posedge aclk); n++; end while (user_tick !== 1'b1 && n < 200);
        chk("tick_period", n - t0, 50);
        if (n >= 200) begin
            error_cnt++;
            test_done();
        end
        @(posedge aclk) irq_event <= 1'b1;
        @(posedge aclk) irq_event <= 1'b0;
        repeat (2) @(negedge aclk);
        chk("irq_active", irq_out, 1);
        i_host_model.wr(A_CMD, 8'h02, r);
        @(posedge aclk) irq_event <= 1'b1;
        @(posedge aclk) irq_event <= 1'b0;
        repeat (12) @(negedge aclk);
        chk("irq_gap", irq_out, 0);
        repeat (12) @(negedge aclk);
        chk("irq_after", irq_out, 1);
        $display("t_tick_irq done");
    endtask
    task automatic t_off();
        @(posedge aclk) link_busy <= 1'b1;
        i_host_model.wr(A_CMD, 8'h04, r);
        repeat (3) @(negedge aclk);
        chk("held", passive_idle, 1);
        @(posedge aclk) link_busy <= 1'b0;
        repeat (3) @(negedge aclk);
        chk("offline", passive_idle, 0);
        i_host_model.wr(A_LO, 8'h00, r);
        chk("unlocked", r, `RESP_OKAY);
        // short gap, pin now active low
        i_host_model.wr(A_HI, 8'h00, r);
        i_host_model.wr(A_CMD, 8'h02, r);
        @(posedge aclk) irq_event <= 1'b1;
        @(posedge aclk) irq_event <= 1'b0;
        repeat (6) @(negedge aclk);
        chk("gap_short", irq_out, 1);
        repeat (6) @(negedge aclk);
        chk("irq_low_active", irq_out, 0);
        $display("t_off done");
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_reset();
        t_mode();
        t_prm();
        t_start();
        t_tick_irq();
        t_off();
        test_done();
    end
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
/*
 host model: axi4-lite master tasks for register access.
 assumes one clock; the slave answers every channel.
*/
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // clock
    input  wire logic        aclk,
    // write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready,
    // a bounded wait ran out
    output logic             hung
);
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready, hung} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        r = bresp;
        bready <= 1'b0;
        if (n >= 200) hung <= 1'b1;
    endtask
    // lat: edges from address take to the edge that sees rvalid
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r,
                      output int lat);
        int n;
        int t;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        t = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                t = n;
            end
        end while (!rvalid && n < 200);
        d = rdata[7:0];
        r = rresp;
        lat = n - t;
        rready <= 1'b0;
        if (n >= 200) hung <= 1'b1;
    endtask
endmodule
`default_nettype wire
